// >>> logic/flash_host_ctrl.sv
// host controller driving a byte-wide parallel flash through its pins
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_defs.svh"
module flash_host_ctrl
(
	input  wire logic                       clk_i,
	input  wire logic                       resetn_i,
	input  wire logic                       clk_en_i,
	input  wire logic [7:0]                 reg_addr_i,
	input  wire logic [31:0]                reg_wdata_i,
	input  wire logic                       reg_wr_i,
	input  wire logic                       reg_rd_i,
	output logic [31:0]                     reg_rdata_o,
	input  wire logic [7:0]                 data_pins_i,
	output var flash_host_pkg::flash_pins_t pins_o
);
	import flash_host_pkg::*;

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic is_alter(input logic [7:0] cmd);
		is_alter = (cmd == `CMD_ERASE_SETUP) || (cmd == `CMD_PROG_SETUP);
	endfunction

	function automatic read_mode_t mode_after(input read_mode_t cur, input logic [7:0] cmd);
		mode_after = cur;
		if (cmd == `CMD_READ_ARRAY)
			mode_after = MODE_ARRAY;
		else if (cmd == `CMD_IDENT)
			mode_after = MODE_IDENT;
		else if ((cmd == `CMD_READ_STATUS) || is_alter(cmd))
			mode_after = MODE_STATUS;
	endfunction

	// ----------------------------------------
	// timers: wake-to-data, wake-to-write, bus phase
	// ----------------------------------------
	localparam logic [11:0] WAKE_DATA_CYC  = 12'(`WAKE_DATA_CYC);
	localparam logic [11:0] WAKE_WRITE_CYC = 12'(`WAKE_WRITE_CYC);
	localparam logic [11:0] ACCESS_CYC     = 12'(`ACCESS_CYC);
	localparam logic [11:0] WE_PULSE_CYC   = 12'(`WE_PULSE_CYC);
	localparam logic [11:0] WE_HOLD_CYC    = 12'(`WE_HOLD_CYC);

	logic [1:0]  wake_done;
	logic [11:0] wake_val [2];
	logic        phase_load;
	logic [11:0] phase_val;
	logic        phase_done;

	assign wake_val[0] = WAKE_DATA_CYC;
	assign wake_val[1] = WAKE_WRITE_CYC;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_wake
			cycle_timer u_wake
			(
				.clk_i      (clk_i),
				.rst_n_i    (rst_n),
				.en_i       (clk_en_i),
				.load_i     (!pins_o.powerdown_reset_n), // RQ8 RQ11
				.load_val_i (wake_val[gi]),
				.done_o     (wake_done[gi])
			);
		end
	endgenerate

	cycle_timer u_phase
	(
		.clk_i      (clk_i),
		.rst_n_i    (rst_n),
		.en_i       (clk_en_i),
		.load_i     (phase_load),
		.load_val_i (phase_val),
		.done_o     (phase_done)
	);

	// ----------------------------------------
	// controller state
	// ----------------------------------------
	host_state_t state;
	host_state_t next_state;
	logic [3:0]  ctrl;
	logic [3:0]  next_ctrl;
	logic [16:0] addr;
	logic [16:0] next_addr;
	logic [7:0]  wbyte;
	logic [7:0]  next_wbyte;
	logic        op_write;
	logic        next_op_write;
	logic [7:0]  rbyte;
	logic [7:0]  next_rbyte;
	logic        refused;
	logic        next_refused;
	logic        blocked;
	logic        next_blocked;
	read_mode_t  mode;
	read_mode_t  next_mode;
	flash_pins_t next_pins;
	logic [31:0] next_rdata;
	logic [31:0] status_word;
	logic        req_rd;
	logic        req_wr;
	logic        pd_req;

	assign req_wr = reg_wr_i && (reg_addr_i == `CMD_OFS);
	assign req_rd = reg_wr_i && (reg_addr_i == `READ_OFS);
	assign pd_req = (reg_wr_i && (reg_addr_i == `CTRL_OFS)) ? reg_wdata_i[`CTRL_PD_BIT]
	                                                        : ctrl[`CTRL_PD_BIT];

	always_comb
	begin
		next_state    = state;
		next_ctrl     = ctrl;
		next_addr     = addr;
		next_wbyte    = wbyte;
		next_op_write = op_write;
		next_rbyte    = rbyte;
		next_refused  = refused;
		next_blocked  = blocked;
		next_mode     = mode;
		next_pins     = pins_o;
		phase_load    = 1'b0;
		phase_val     = ACCESS_CYC;
		if (reg_wr_i && (reg_addr_i == `CTRL_OFS))
			next_ctrl = reg_wdata_i[3:0];
		if (reg_wr_i && (reg_addr_i == `ADDR_OFS))
			next_addr = reg_wdata_i[16:0];
		if (reg_wr_i && (reg_addr_i == `STAT_OFS))
		begin
			if (reg_wdata_i[`STAT_REFUSE_BIT])
				next_refused = 1'b0;
			if (reg_wdata_i[`STAT_BLOCK_BIT])
				next_blocked = 1'b0;
		end
		next_pins.program_supply_high     = next_ctrl[`CTRL_VPP_BIT];
		next_pins.identifier_high_voltage = next_ctrl[`CTRL_ID_BIT]; // RQ13
		next_pins.unlock_high_voltage     = next_ctrl[`CTRL_UNLOCK_BIT]; // RQ19
		next_pins.powerdown_reset_n       = !pd_req; // RQ20
		case (state)
			ST_IDLE:
			begin
				if ((req_rd || req_wr) && !pd_req)
				begin
					next_op_write = req_wr;
					if (req_wr)
						next_wbyte = reg_wdata_i[7:0];
					next_state = ST_WAKE;
				end
			end
			ST_WAKE:
			begin
				if (op_write && wake_done[1]) // RQ11
				begin
					next_pins.chip_select_n  = 1'b0;
					next_pins.output_drive_n = 1'b1;
					next_pins.write_strobe_n = 1'b0;
					next_pins.address        = addr;
					next_pins.data_pins      = wbyte;
					next_pins.data_pins_oe_n = 1'b0;
					phase_load = 1'b1;
					phase_val  = WE_PULSE_CYC;
					next_state = ST_WR_LOW;
				end
				else if (!op_write && wake_done[0]) // RQ8
				begin
					next_pins.chip_select_n  = 1'b0; // RQ3
					next_pins.output_drive_n = 1'b0;
					next_pins.write_strobe_n = 1'b1;
					next_pins.address        = addr;
					next_pins.data_pins_oe_n = 1'b1;
					phase_load = 1'b1;
					phase_val  = ACCESS_CYC;
					next_state = ST_READ;
				end
			end
			ST_READ:
			begin
				if (phase_done)
				begin
					next_rbyte = data_pins_i;
					next_pins.chip_select_n  = 1'b1;
					next_pins.output_drive_n = 1'b1;
					next_state = ST_IDLE;
				end
			end
			ST_WR_LOW:
			begin
				if (phase_done)
				begin
					next_pins.write_strobe_n = 1'b1; // RQ21
					phase_load = 1'b1;
					phase_val  = WE_HOLD_CYC;
					next_state = ST_WR_HIGH;
				end
			end
			ST_WR_HIGH:
			begin
				if (phase_done)
				begin
					next_pins.chip_select_n  = 1'b1;
					next_pins.data_pins_oe_n = 1'b1;
					next_mode = mode_after(mode, wbyte); // RQ14 RQ22 RQ23
					if (is_alter(wbyte) && !ctrl[`CTRL_VPP_BIT])
						next_blocked = 1'b1;
					next_state = ST_IDLE;
				end
			end
			default:
				next_state = ST_IDLE;
		endcase
		if ((req_rd || req_wr) && ((state != ST_IDLE) || pd_req))
			next_refused = 1'b1;
		if (pd_req)
		begin
			next_state               = ST_IDLE;
			next_mode                = MODE_ARRAY; // RQ2 RQ9
			next_pins.chip_select_n  = 1'b1;
			next_pins.output_drive_n = 1'b1;
			next_pins.write_strobe_n = 1'b1;
			next_pins.data_pins_oe_n = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state    <= ST_IDLE;
			ctrl     <= `CTRL_RST;
			addr     <= 17'h00000;
			wbyte    <= 8'h00;
			op_write <= 1'b0;
			rbyte    <= 8'h00;
			refused  <= 1'b0;
			blocked  <= 1'b0;
			mode     <= MODE_ARRAY;
			pins_o   <= '{chip_select_n: 1'b1, output_drive_n: 1'b1,
			              write_strobe_n: 1'b1, powerdown_reset_n: 1'b0,
			              address: 17'h00000, data_pins: 8'h00,
			              data_pins_oe_n: 1'b1, program_supply_high: 1'b0,
			              identifier_high_voltage: 1'b0, unlock_high_voltage: 1'b0};
		end
		else if (clk_en_i)
		begin
			state    <= next_state;
			ctrl     <= next_ctrl;
			addr     <= next_addr;
			wbyte    <= next_wbyte;
			op_write <= next_op_write;
			rbyte    <= next_rbyte;
			refused  <= next_refused;
			blocked  <= next_blocked;
			mode     <= next_mode;
			pins_o   <= next_pins;
		end
	end

	// ----------------------------------------
	// register read-back
	// ----------------------------------------
	always_comb
	begin
		status_word = 32'h00000000;
		status_word[`STAT_BUSY_BIT]   = (state != ST_IDLE);
		status_word[`STAT_WDATA_BIT]  = !wake_done[0];
		status_word[`STAT_WWRITE_BIT] = !wake_done[1];
		status_word[`STAT_REFUSE_BIT] = refused;
		status_word[`STAT_BLOCK_BIT]  = blocked;
		status_word[`STAT_MODE_LSB +: 2] = mode; // RQ1
		status_word[`STAT_DATA_LSB +: 8] = rbyte;
		next_rdata = 32'h00000000;
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				`CTRL_OFS: next_rdata = {28'h0000000, ctrl};
				`ADDR_OFS: next_rdata = {15'h0000, addr};
				`STAT_OFS: next_rdata = status_word;
				`DATA_OFS: next_rdata = {24'h000000, rbyte};
				default:   next_rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata_o <= 32'h00000000;
		else if (clk_en_i)
			reg_rdata_o <= next_rdata;
	end
endmodule
`default_nettype wire

// >>> logic/flash_host_defs.svh
// constants for the parallel flash host controller
// Behaviour
// RQ1 - three read modes: array, identifier, status
// RQ2 - array read after power-up and wake
// RQ3 - read: select, drive low; powerdown, strobe high
// RQ4 - output drive high floats data pins
// RQ5 - select high means standby, pins float
// RQ6 - deselect mid-operation still completes operation
// RQ7 - powerdown low deselects, floats, powers off
// RQ8 - no valid data before wake-to-data delay
// RQ9 - wake sets array mode, status 80h
// RQ10 - powerdown low aborts erase or program
// RQ11 - wait wake-to-write delay before command writes
// RQ12 - erase, program need high program supply
// RQ13 - identifier voltage on bit nine gives codes
// RQ14 - after 90h, address zero/one give codes
// RQ15 - identifier command works without high supply
// RQ16 - read modes work at either supply
// RQ17 - command latch unaddressed, feeds write automaton
// RQ18 - commands govern status; alteration needs supply
// RQ19 - boot block needs unlock high voltage
// RQ20 - powerdown pin follows system reset
// RQ21 - command captured at strobe rising edge
// RQ22 - FFh selects array read mode
// RQ23 - 70h selects status read until changed
// RQ24 - synchronous sampling, strobe edges, decoded enables
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

// ----------------------------------------
// software register offsets
// ----------------------------------------
`define CTRL_OFS        8'h00
`define ADDR_OFS        8'h04
`define CMD_OFS         8'h08
`define READ_OFS        8'h0c
`define STAT_OFS        8'h10
`define DATA_OFS        8'h14

// ----------------------------------------
// control field positions
// ----------------------------------------
`define CTRL_PD_BIT     0
`define CTRL_VPP_BIT    1
`define CTRL_ID_BIT     2
`define CTRL_UNLOCK_BIT 3
`define CTRL_RST        4'h0

// ----------------------------------------
// status field positions
// ----------------------------------------
`define STAT_BUSY_BIT   0
`define STAT_WDATA_BIT  1
`define STAT_WWRITE_BIT 2
`define STAT_REFUSE_BIT 3
`define STAT_BLOCK_BIT  4
`define STAT_MODE_LSB   8
`define STAT_DATA_LSB   16

// ----------------------------------------
// flash command codes
// ----------------------------------------
`define CMD_READ_ARRAY   8'hff
`define CMD_IDENT        8'h90
`define CMD_READ_STATUS  8'h70
`define CMD_ERASE_SETUP  8'h20
`define CMD_PROG_SETUP   8'h40

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ          250
`define WAKE_DATA_NS     600
`define WAKE_WRITE_NS    600
`define ACCESS_NS        150
`define WE_PULSE_NS      50
`define WE_HOLD_NS       20
`define NS_TO_CYC(ns)    (((ns) * `CLK_MHZ + 999) / 1000)
`define WAKE_DATA_CYC    `NS_TO_CYC(`WAKE_DATA_NS)
`define WAKE_WRITE_CYC   `NS_TO_CYC(`WAKE_WRITE_NS)
`define ACCESS_CYC       `NS_TO_CYC(`ACCESS_NS)
`define WE_PULSE_CYC     `NS_TO_CYC(`WE_PULSE_NS)
`define WE_HOLD_CYC      `NS_TO_CYC(`WE_HOLD_NS)

`endif

// >>> logic/flash_host_pkg.sv
// types shared by the flash host controller
`default_nettype none
package flash_host_pkg;

	// ----------------------------------------
	// pins toward the flash
	// ----------------------------------------
	typedef struct packed {
		logic        chip_select_n;
		logic        output_drive_n;
		logic        write_strobe_n;
		logic        powerdown_reset_n;
		logic [16:0] address;
		logic [7:0]  data_pins;
		logic        data_pins_oe_n;
		logic        program_supply_high;
		logic        identifier_high_voltage;
		logic        unlock_high_voltage;
	} flash_pins_t;

	typedef enum logic [1:0] {
		MODE_ARRAY  = 2'h0,
		MODE_IDENT  = 2'h1,
		MODE_STATUS = 2'h2
	} read_mode_t;

	typedef enum logic [4:0] {
		ST_IDLE    = 5'h01,
		ST_WAKE    = 5'h02,
		ST_READ    = 5'h04,
		ST_WR_LOW  = 5'h08,
		ST_WR_HIGH = 5'h10
	} host_state_t;

endpackage
`default_nettype wire

// >>> logic/cycle_timer.sv
// loadable down-counter for bus phase and wake delays
`timescale 1ns/1ps
`default_nettype none
module cycle_timer
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        en_i,
	input  wire logic        load_i,
	input  wire logic [11:0] load_val_i,
	output logic             done_o
);
	logic [11:0] count;
	logic [11:0] next_count;

	always_comb
	begin
		next_count = count;
		if (load_i)
			next_count = load_val_i;
		else if (count != 12'h000)
			next_count = count - 12'h001;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			count <= 12'h000;
		else if (en_i)
			count <= next_count;
	end

	assign done_o = (count == 12'h000);
endmodule
`default_nettype wire

// >>> tb/flash_dev_model.sv
// behavioural byte-wide flash device answering the host pins
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
#(
	parameter logic [7:0] MFR  = 8'h5a, // arbitrary value
	parameter logic [7:0] DEV  = 8'h3c, // arbitrary value
	parameter int         ACC  = 100,
	parameter real        WAKE = 600.0
)
(
	input  wire flash_host_pkg::flash_pins_t pins_i,
	output logic [7:0]                       data_o
);
	import flash_host_pkg::*;
	logic [7:0] mem [16];
	logic [7:0] stat = 8'h80;
	logic [1:0] mode = 2'h0;
	logic       prog = 1'b0;
	realtime    t_up = 0;
	logic [7:0] rd;
	logic       on;
	initial foreach (mem[i]) mem[i] = 8'(i) ^ 8'ha5;
	// ----------------------------------------
	// command latch
	// ----------------------------------------
	always @(posedge pins_i.write_strobe_n)
	begin
		if (!pins_i.chip_select_n && pins_i.powerdown_reset_n)
		begin
			if (prog)
			begin
				if (pins_i.program_supply_high)
					mem[pins_i.address[3:0]] = pins_i.data_pins;
				else
					stat = 8'h88;
				prog = 1'b0;
				mode = 2'h2;
			end
			else
				case (pins_i.data_pins)
					8'hff: mode = 2'h0;
					8'h90: mode = 2'h1;
					8'h70: mode = 2'h2;
					8'h50: stat = 8'h80;
					8'h40: prog = 1'b1;
					default: ;
				endcase
		end
	end
	always @(pins_i.powerdown_reset_n)
	begin
		mode = 2'h0;
		stat = 8'h80;
		prog = 1'b0;
		t_up = $realtime;
	end
	// ----------------------------------------
	// read path
	// ----------------------------------------
	always @*
	begin
		if (pins_i.identifier_high_voltage || mode == 2'h1)
			rd = pins_i.address[0] ? DEV : MFR;
		else if (mode == 2'h2)
			rd = stat;
		else
			rd = mem[pins_i.address[3:0]];
		on = !pins_i.chip_select_n && !pins_i.output_drive_n
			&& pins_i.powerdown_reset_n && ($realtime - t_up >= WAKE);
	end
	assign #(ACC) data_o = on ? rd : ~rd;
endmodule
`default_nettype wire

// >>> tb/flash_host_monitor.sv
// concurrent checks on the flash host controller ports
`timescale 1ns/1ps
`default_nettype none
module flash_host_monitor
(
	input  wire logic                        clk_i,
	input  wire logic                        resetn_i,
	input  wire logic                        reg_rd_i,
	input  wire logic [31:0]                 reg_rdata_o,
	input  wire flash_host_pkg::flash_pins_t pins_o
);
	import flash_host_pkg::*;
	logic [7:0] up_cnt;
	logic [7:0] next_up_cnt;
	always_comb
	begin
		next_up_cnt = up_cnt;
		if (!pins_o.powerdown_reset_n)
			next_up_cnt = 8'h00;
		else if (up_cnt != 8'hff)
			next_up_cnt = up_cnt + 8'h01;
	end
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			up_cnt <= 8'h00;
		else
			up_cnt <= next_up_cnt;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	sequence we_low;
		$fell(pins_o.write_strobe_n);
	endsequence
	sequence we_held;
		(!pins_o.write_strobe_n && !pins_o.chip_select_n)[*8] ##[1:20] pins_o.write_strobe_n;
	endsequence
	a_read_pins: assert property (!pins_o.chip_select_n && !pins_o.output_drive_n
		|-> pins_o.powerdown_reset_n && pins_o.write_strobe_n) else $error("bad read pins");
	a_no_contention: assert property (!pins_o.output_drive_n
		|-> pins_o.data_pins_oe_n) else $error("host drives during read");
	a_idle_released: assert property (pins_o.chip_select_n
		|-> pins_o.write_strobe_n && pins_o.output_drive_n && pins_o.data_pins_oe_n)
		else $error("strobes active while deselected");
	a_pd_deselects: assert property (!pins_o.powerdown_reset_n
		|-> pins_o.chip_select_n) else $error("select during powerdown");
	a_data_wake: assert property (!pins_o.output_drive_n
		|-> up_cnt >= 8'd150) else $error("read before wake delay");
	a_write_wake: assert property (!pins_o.write_strobe_n
		|-> up_cnt >= 8'd150) else $error("write before wake delay");
	a_strobe_width: assert property (we_low |-> we_held)
		else $error("write strobe too short");
	a_bus_stable: assert property (!pins_o.chip_select_n && !$past(pins_o.chip_select_n)
		|-> $stable(pins_o.address) && $stable(pins_o.data_pins)) else $error("bus moved");
	a_rdata_idle: assert property (!$past(reg_rd_i)
		|-> reg_rdata_o == 32'h0) else $error("read data outside slot");
endmodule
bind flash_host_ctrl flash_host_monitor u_mon (.clk_i(clk_i), .resetn_i(resetn_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pins_o(pins_o));
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_defs.svh"
module testbench;
	import flash_host_pkg::*;
	localparam logic [7:0] MFR = 8'h5a; // arbitrary value
	localparam logic [7:0] DEV = 8'h3c; // arbitrary value
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        clk_en = 1'b1;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic [7:0]  dev_dq;
	logic [7:0]  dq;
	flash_pins_t pins;
	int          n_errors = 0;
	int          compares = 0;
	logic [31:0] s;
	always #2 clk = ~clk;
	assign dq = pins.data_pins_oe_n ? dev_dq : pins.data_pins;
	flash_host_ctrl u_dut (.clk_i(clk), .resetn_i(resetn), .clk_en_i(clk_en),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
		.reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .data_pins_i(dq), .pins_o(pins));
	flash_dev_model #(.MFR(MFR), .DEV(DEV)) u_dev (.pins_i(pins), .data_o(dev_dq));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic end_of_test();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge clk);
	endtask
	task automatic idle();
		logic [31:0] st;
		for (int i = 0; i < 400; i++)
		begin
			rd(`STAT_OFS, st);
			if (st[2:0] === 3'h0)
				return;
		end
		n_errors++;
		end_of_test();
	endtask
	task automatic fcmd(input logic [16:0] a, input logic [7:0] c);
		wr(`ADDR_OFS, {15'h0, a});
		wr(`CMD_OFS, {24'h0, c});
		idle();
	endtask
	task automatic frd(input logic [16:0] a, input logic [7:0] e);
		logic [31:0] d;
		wr(`ADDR_OFS, {15'h0, a});
		wr(`READ_OFS, 32'h0);
		idle();
		rd(`DATA_OFS, d);
		chk(d, {24'h0, e});
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_boot();
		rd(`CTRL_OFS, s);
		chk(s, 32'h0);
		rd(8'h18, s);
		chk(s, 32'h0);
		rd(`STAT_OFS, s);
		chk(s[`STAT_MODE_LSB +: 2], 2'h0);
		frd(5, 8'ha0);
	endtask
	task automatic t_modes();
		fcmd(0, 8'h90);
		frd(0, MFR);
		frd(1, DEV);
		rd(`STAT_OFS, s);
		chk(s[`STAT_MODE_LSB +: 2], 2'h1);
		fcmd(0, 8'h70);
		frd(0, 8'h80);
		fcmd(0, 8'hff);
		frd(3, 8'ha6);
	endtask
	task automatic t_alter();
		fcmd(5, 8'h40);
		fcmd(5, 8'h33);
		rd(`STAT_OFS, s);
		chk(s[`STAT_BLOCK_BIT], 1'b1);
		wr(`STAT_OFS, 32'h1 << `STAT_BLOCK_BIT);
		rd(`STAT_OFS, s);
		chk(s[`STAT_BLOCK_BIT], 1'b0);
		frd(0, 8'h88);
		fcmd(0, 8'hff);
		frd(5, 8'ha0);
		fcmd(0, 8'h50);
		wr(`CTRL_OFS, 32'h1 << `CTRL_VPP_BIT);
		fcmd(5, 8'h40);
		fcmd(5, 8'h33);
		fcmd(0, 8'hff);
		frd(5, 8'h33);
		wr(`CTRL_OFS, 32'h0);
	endtask
	task automatic t_pd();
		wr(`ADDR_OFS, 32'h0);
		wr(`CMD_OFS, 32'h70);
		repeat (9) @(posedge clk);
		wr(`CTRL_OFS, 32'h1 << `CTRL_PD_BIT);
		@(posedge clk);
		#1 chk({pins.chip_select_n, pins.write_strobe_n, pins.powerdown_reset_n}, 3'h6);
		wr(`CMD_OFS, 32'hff);
		rd(`STAT_OFS, s);
		chk(s[`STAT_REFUSE_BIT], 1'b1);
		wr(`CTRL_OFS, 32'h0);
		rd(`STAT_OFS, s);
		chk(s[`STAT_WDATA_BIT], 1'b1);
		idle();
		rd(`STAT_OFS, s);
		chk(s[`STAT_MODE_LSB +: 2], 2'h0);
		frd(5, 8'h33);
		fcmd(0, 8'h70);
		frd(0, 8'h80);
	endtask
	task automatic t_idv();
		wr(`CTRL_OFS, 32'h1 << `CTRL_ID_BIT);
		fcmd(0, 8'hff);
		frd(1, DEV);
		frd(0, MFR);
		wr(`CTRL_OFS, 32'h0);
	endtask
	task automatic t_freeze();
		fcmd(5, 8'h20);
		rd(`STAT_OFS, s);
		chk(s[`STAT_BLOCK_BIT], 1'b1);
		chk(s[`STAT_MODE_LSB +: 2], 2'h2);
		wr(`STAT_OFS, 32'h1 << `STAT_BLOCK_BIT);
		fcmd(6, 8'hff);
		rd(`ADDR_OFS, s);
		chk(s, 32'h6);
		wr(`READ_OFS, 32'h0);
		repeat (4) @(posedge clk);
		clk_en <= 1'b0;
		repeat (60) @(posedge clk);
		#1 chk({pins.chip_select_n, pins.output_drive_n}, 2'h0);
		@(posedge clk);
		clk_en <= 1'b1;
		idle();
		rd(`DATA_OFS, s);
		chk(s, 32'ha3);
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		idle();
		t_boot();
		t_modes();
		t_alter();
		t_pd();
		t_idv();
		t_freeze();
		end_of_test();
	end
endmodule
`default_nettype wire
